// >>> rtl/compass_cfg.svh
// constants for the compass serial mode block
`ifndef COMPASS_CFG_SVH
`define COMPASS_CFG_SVH
`define CLK_HZ          200000000
`define BAUD_2400       2400
`define BAUD_4800       4800
`define BAUD_9600       9600
`define BAUD_19200      19200
`define CONT_PERIOD_MS  500
`define MS_PER_S        1000
`define FRAME_LAST_BIT  4'h9
`define LAST_BYTE       2'h2
`define REG_CTRL        8'h00
`define REG_HEADING     8'h04
`define REG_STATUS      8'h08
`define REG_PKT_CNT     8'h0c
`define CTRL_RST        32'h0000_0000
`define HEADING_RST     16'h0000
`define HEADING_MAX     16'h02cf
`define HEADING_WRAP    16'h02d0
`define PKT_HIGH_BITS   7'h40
`define CAL_START_MSG   24'h535441
`define CAL_READY_MSG   24'h524459
`define STAT_STATE_LSB  0
`define STAT_BUSY_BIT   8
`define STAT_RTS_BIT    9
`define STAT_RXD_BIT    10
`define STAT_STRAP_LSB  12
`endif

// >>> rtl/compass_pkg.sv
// types for the compass serial mode block
package compass_pkg;
    typedef enum logic [5:0] {
        ST_SLEEP    = 6'h01,
        ST_PKT      = 6'h02,
        ST_GAP      = 6'h04,
        ST_CAL_START = 6'h08,
        ST_CAL_WAIT = 6'h10,
        ST_CAL_RDY  = 6'h20
    } mode_state_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } ahb_req_t;

    typedef struct packed {
        logic factory_test;
        logic y_axis_invert;
        logic baud_b;
        logic baud_a;
    } straps_t;
endpackage

// >>> rtl/compass_serial_mode.sv
// serial mode protocol of the heading sensor module, with ahb-lite registers
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "compass_cfg.svh"

// Notes on behaviour
// - strap reads 1 with jumper absent, 0 with jumper fitted.
// - straps a,b select 2400, 4800, 9600 or 19200 baud.
// - frames are 8 data bits, no parity, one stop bit; default 2400.
// - y-invert strap mirrors the heading; factory test strap only reported.
// - sleep by default; leave only when request-to-send goes low.
// - request and receive inputs read high when left open.
// - normal mode: request pulse with receive high sends one status packet.
// - after a normal packet, sleep again if request-to-send is high.
// - polled requests up to twenty per second if baud allows.
// - request held low with receive high repeats the packet about twice per second.
// - continuous output stops and device sleeps when request-to-send goes high.
// - request pulse with receive low enters calibration while receive stays low.
// - calibration entry sends bytes 53, 54, 41.
// - first packet byte is 80 or 81.
// - first byte lsb set when distortion flagged.
// - bytes two and three hold heading, msb first, half degrees.
module compass_serial_mode #(
    parameter int CONT_PERIOD_CYC = (`CLK_HZ / `MS_PER_S) * `CONT_PERIOD_MS,
    parameter int DIV_2400        = `CLK_HZ / `BAUD_2400,
    parameter int DIV_4800        = `CLK_HZ / `BAUD_4800,
    parameter int DIV_9600        = `CLK_HZ / `BAUD_9600,
    parameter int DIV_19200       = `CLK_HZ / `BAUD_19200
) (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_N_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic             HREADYOUT_O,
    output logic [31:0]      HRDATA_O,
    output logic             HRESP_O,
    input  wire logic        RTS_N_I,
    input  wire logic        RXD_I,
    output logic             TXD_O,
    input  wire logic        BAUD_STRAP_A_I,
    input  wire logic        BAUD_STRAP_B_I,
    input  wire logic        Y_AXIS_INVERT_STRAP_I,
    input  wire logic        FACTORY_TEST_STRAP_I
);
    ////////////////////////////////////////////////////////////////////////////
    logic                     rst_meta_ff, rst_sync_ff;
    logic [5:0]               pin_meta_ff, pin_sync_ff;
    logic                     rts_d_ff;
    compass_pkg::straps_t     straps;
    logic                     rts_high, rxd_high, rts_fall;

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // open inputs idle high, so the synchronisers also reset to ones
    always_ff @(posedge CLK_SYS_I or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            pin_meta_ff <= 6'h3f;
            pin_sync_ff <= 6'h3f;
            rts_d_ff    <= 1'b1;
        end else begin
            pin_meta_ff <= {RTS_N_I, RXD_I, FACTORY_TEST_STRAP_I, Y_AXIS_INVERT_STRAP_I,
                            BAUD_STRAP_B_I, BAUD_STRAP_A_I};
            pin_sync_ff <= pin_meta_ff;
            rts_d_ff    <= pin_sync_ff[5];
        end
    end

    assign rts_high = pin_sync_ff[5];
    assign rxd_high = pin_sync_ff[4];
    assign straps   = compass_pkg::straps_t'(pin_sync_ff[3:0]);
    assign rts_fall = rts_d_ff & ~rts_high;

    ////////////////////////////////////////////////////////////////////////////
    compass_pkg::ahb_req_t req_ff;
    logic [31:0]           ctrl_ff, hrdata_ff;
    logic [15:0]           heading_ff, pkt_cnt_ff;
    logic [15:0]           heading_wr, heading_eff;
    logic [31:0]           status_word, rd_word;
    logic                  addr_take, wr_ctrl, wr_heading;
    compass_pkg::mode_state_t state_ff, nxt_state;
    logic                  tx_busy_ff;

    // zero wait states: every transfer completes in its first data phase
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;
    assign HRDATA_O    = hrdata_ff;
    assign addr_take   = HSEL_I & HTRANS_I[1] & HREADY_I;
    assign wr_ctrl     = req_ff.valid & req_ff.write & (req_ff.addr == `REG_CTRL);
    assign wr_heading  = req_ff.valid & req_ff.write & (req_ff.addr == `REG_HEADING);
    // out-of-range headings saturate rather than wrap
    assign heading_wr  = (HWDATA_I[15:0] > `HEADING_MAX) ? `HEADING_MAX : HWDATA_I[15:0];
    // negating y mirrors the bearing about north
    assign heading_eff = (straps.y_axis_invert == 1'b0) && (heading_ff != `HEADING_RST)
                         ? `HEADING_WRAP - heading_ff : heading_ff;

    assign status_word = {16'h0000, pin_sync_ff[3:0], 1'b0, rxd_high, rts_high, tx_busy_ff,
                          2'b00, state_ff};
    assign rd_word = (HADDR_I[7:0] == `REG_CTRL)    ? ctrl_ff :
                     (HADDR_I[7:0] == `REG_HEADING) ? {16'h0000, heading_ff} :
                     (HADDR_I[7:0] == `REG_STATUS)  ? status_word :
                     (HADDR_I[7:0] == `REG_PKT_CNT) ? {16'h0000, pkt_cnt_ff} : 32'h0000_0000;

    always_ff @(posedge CLK_SYS_I or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            req_ff    <= '0;
            hrdata_ff <= 32'h0000_0000;
        end else begin
            req_ff    <= '{valid: addr_take, write: HWRITE_I, addr: HADDR_I[7:0]};
            hrdata_ff <= (addr_take & ~HWRITE_I) ? rd_word : hrdata_ff;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            ctrl_ff    <= `CTRL_RST;
            heading_ff <= `HEADING_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= {31'h0000_0000, HWDATA_I[0]};
            end
            if (wr_heading) begin
                heading_ff <= heading_wr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [16:0] baud_div, baud_cnt_ff;
    logic [3:0]  bit_cnt_ff;
    logic [1:0]  byte_idx_ff;
    logic [9:0]  shift_ff;
    logic [23:0] msg_ff, msg;
    logic [26:0] gap_cnt_ff;
    logic        txd_ff, baud_tick, tx_done, tx_start, gap_done;

    // strap a is the first figure of the pair
    assign baud_div = ({straps.baud_a, straps.baud_b} == 2'b11) ? 17'(DIV_2400) :
                      ({straps.baud_a, straps.baud_b} == 2'b10) ? 17'(DIV_4800) :
                      ({straps.baud_a, straps.baud_b} == 2'b01) ? 17'(DIV_9600) : 17'(DIV_19200);
    assign baud_tick = tx_busy_ff & (baud_cnt_ff == baud_div - 17'h00001);
    assign tx_done   = baud_tick & (bit_cnt_ff == `FRAME_LAST_BIT) & (byte_idx_ff == `LAST_BYTE);
    assign gap_done  = (gap_cnt_ff == 27'(CONT_PERIOD_CYC - 1));

    // status packet: fixed top bit, distortion in lsb, heading msb first
    assign msg = (state_ff == compass_pkg::ST_SLEEP && !rxd_high) ? `CAL_START_MSG :
                 (state_ff == compass_pkg::ST_CAL_WAIT)           ? `CAL_READY_MSG :
                 {`PKT_HIGH_BITS, ctrl_ff[0], heading_eff};

    always_comb begin
        nxt_state = state_ff;
        tx_start  = 1'b0;
        unique case (state_ff)
            compass_pkg::ST_SLEEP: begin
                if (rts_fall) begin
                    tx_start  = 1'b1;
                    nxt_state = rxd_high ? compass_pkg::ST_PKT : compass_pkg::ST_CAL_START;
                end
            end
            compass_pkg::ST_PKT: begin
                if (tx_done) begin
                    nxt_state = rts_high ? compass_pkg::ST_SLEEP : compass_pkg::ST_GAP;
                end
            end
            compass_pkg::ST_GAP: begin
                if (rts_high) begin
                    nxt_state = compass_pkg::ST_SLEEP;
                end else if (gap_done) begin
                    tx_start  = 1'b1;
                    nxt_state = compass_pkg::ST_PKT;
                end
            end
            compass_pkg::ST_CAL_START: begin
                if (tx_done) begin
                    nxt_state = compass_pkg::ST_CAL_WAIT;
                end
            end
            compass_pkg::ST_CAL_WAIT: begin
                if (rxd_high) begin
                    tx_start  = 1'b1;
                    nxt_state = compass_pkg::ST_CAL_RDY;
                end
            end
            compass_pkg::ST_CAL_RDY: begin
                if (tx_done) begin
                    nxt_state = compass_pkg::ST_SLEEP;
                end
            end
            default: nxt_state = compass_pkg::ST_SLEEP;
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            state_ff   <= compass_pkg::ST_SLEEP;
            gap_cnt_ff <= 27'h0000000;
            pkt_cnt_ff <= 16'h0000;
        end else begin
            state_ff   <= nxt_state;
            gap_cnt_ff <= (state_ff == compass_pkg::ST_GAP && !gap_done) ? gap_cnt_ff + 27'h0000001
                                                                         : 27'h0000000;
            if (tx_done && state_ff == compass_pkg::ST_PKT) begin
                pkt_cnt_ff <= pkt_cnt_ff + 16'h0001;
            end
        end
    end

    // 8n1 shifter: start bit, lsb first, stop bit, three bytes back to back
    always_ff @(posedge CLK_SYS_I or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            tx_busy_ff  <= 1'b0;
            baud_cnt_ff <= 17'h00000;
            bit_cnt_ff  <= 4'h0;
            byte_idx_ff <= 2'h0;
            shift_ff    <= 10'h3ff;
            msg_ff      <= 24'h000000;
            txd_ff      <= 1'b1;
        end else begin
            txd_ff <= tx_busy_ff ? shift_ff[0] : 1'b1;
            if (tx_start) begin
                tx_busy_ff  <= 1'b1;
                baud_cnt_ff <= 17'h00000;
                bit_cnt_ff  <= 4'h0;
                byte_idx_ff <= 2'h0;
                shift_ff    <= {1'b1, msg[23:16], 1'b0};
                msg_ff      <= {msg[15:0], 8'h00};
            end else if (baud_tick) begin
                baud_cnt_ff <= 17'h00000;
                if (bit_cnt_ff != `FRAME_LAST_BIT) begin
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    shift_ff   <= {1'b1, shift_ff[9:1]};
                end else if (byte_idx_ff == `LAST_BYTE) begin
                    tx_busy_ff <= 1'b0;
                end else begin
                    bit_cnt_ff  <= 4'h0;
                    byte_idx_ff <= byte_idx_ff + 2'h1;
                    shift_ff    <= {1'b1, msg_ff[23:16], 1'b0};
                    msg_ff      <= {msg_ff[15:0], 8'h00};
                end
            end else if (tx_busy_ff) begin
                baud_cnt_ff <= baud_cnt_ff + 17'h00001;
            end
        end
    end

    assign TXD_O = txd_ff;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!rst_sync_ff);

    // reply words kept whole and named so the checks can slice out their bytes
    localparam logic [23:0] calibration_start_reply = `CAL_START_MSG;
    localparam logic [23:0] cal_ready_reply         = `CAL_READY_MSG;

    a_sleep_wakes:   assert property (state_ff == compass_pkg::ST_SLEEP && rts_fall
                                      |=> state_ff != compass_pkg::ST_SLEEP && tx_busy_ff)
        else $error("no wake on request");
    a_baud_select:   assert property (!straps.baud_a && !straps.baud_b |-> baud_div == 17'(DIV_19200))
        else $error("wrong divisor for fitted straps");
    a_pkt_header:    assert property (tx_start && nxt_state == compass_pkg::ST_PKT
                                      |=> shift_ff[8:2] == `PKT_HIGH_BITS && shift_ff[1] == ctrl_ff[0])
        else $error("bad first packet byte");
    a_heading_range: assert property (heading_eff <= `HEADING_MAX)
        else $error("heading out of range");
    a_cal_start:     assert property (state_ff == compass_pkg::ST_SLEEP && rts_fall && !rxd_high
                                      |=> shift_ff[8:1] == calibration_start_reply[23:16]
                                          ##0 msg_ff[23:8] == calibration_start_reply[15:0])
        else $error("bad calibration start reply");
    a_cal_ready:     assert property (state_ff == compass_pkg::ST_CAL_WAIT && rxd_high
                                      |=> state_ff == compass_pkg::ST_CAL_RDY
                                          ##0 shift_ff[8:1] == cal_ready_reply[23:16])
        else $error("no ready reply");
    a_cont_stop:     assert property (state_ff == compass_pkg::ST_GAP && rts_high
                                      |=> state_ff == compass_pkg::ST_SLEEP ##0 !tx_busy_ff)
        else $error("continuous output did not stop");
    a_normal_return: assert property (state_ff == compass_pkg::ST_PKT && tx_done && rts_high
                                      |=> state_ff == compass_pkg::ST_SLEEP)
        else $error("no sleep after packet");
    a_idle_line:     assert property (!tx_busy_ff |=> TXD_O)
        else $error("line not idle high");
    a_start_bit:     assert property (tx_start |=> ##1 !TXD_O)
        else $error("missing start bit");

    c_normal_pkt: cover property (state_ff == compass_pkg::ST_PKT && tx_done && rts_high);
    c_cont_repeat: cover property (state_ff == compass_pkg::ST_GAP && gap_done && !rts_high);
    c_cal_done: cover property (state_ff == compass_pkg::ST_CAL_RDY && tx_done);
endmodule
`default_nettype wire

// >>> testbench/compass_host.sv
// host-side model: drives the request and receive lines and decodes the serial output
`timescale 1ns/10ps
`default_nettype none
module compass_host (
    input  wire logic        clk_i,
    input  wire logic [31:0] bit_cyc_i,
    input  wire logic        txd_i,
    output logic             rts_n_o,
    output logic             rxd_o
);
    logic [7:0] rx_q [$];
    int         frame_err = 0;

    // both lines rest high, as the pull-ups would leave them
    initial begin
        rts_n_o = 1'b1;
        rxd_o   = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse or hold the request line, receive level set in the same cycle
    task automatic request(input logic rxd_lvl, input logic hold);
        @(posedge clk_i);
        rxd_o   <= rxd_lvl;
        rts_n_o <= 1'b0;
        if (!hold) begin
            repeat (4) @(posedge clk_i);
            rts_n_o <= 1'b1;
        end
    endtask

    task automatic release_rts();
        @(posedge clk_i);
        rts_n_o <= 1'b1;
    endtask

    // receive stays low for the whole rotation, raised only at its end
    task automatic end_cal();
        @(posedge clk_i);
        rxd_o <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // 8n1 receiver, lsb first, sampled mid-bit
    always begin : rx
        logic [7:0] b;
        @(negedge txd_i);
        repeat (bit_cyc_i / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc_i) @(posedge clk_i);
            b[i] = txd_i;
        end
        repeat (bit_cyc_i) @(posedge clk_i);
        if (txd_i !== 1'b1) begin
            frame_err++;
        end
        rx_q.push_back(b);
    end
endmodule
`default_nettype wire

// >>> testbench/compass_serial_mode_protocol_bench.sv
// self-checking bench for the compass serial mode block
`timescale 1ns/10ps
`default_nettype none
`include "compass_cfg.svh"
module compass_serial_mode_protocol_bench;
    localparam int CONT  = 2000;
    localparam int LIMIT = 60000;
    logic        clk, rst_n, hsel, hwrite, hready, hresp, txd, rts_n, rxd, sa, sb, yinv, ftest, flag;
    logic [31:0] haddr, hwdata, hrdata, rd, bitc, seed;
    logic [1:0]  htrans;
    logic [15:0] h;
    int          err_total = 0, checks_done = 0, cyc = 0, base, t0;

    compass_serial_mode #(.CONT_PERIOD_CYC(CONT), .DIV_2400(128), .DIV_4800(64), .DIV_9600(32),
                          .DIV_19200(16)) DUT (
        .CLK_SYS_I             (clk),
        .RST_N_I               (rst_n),
        .HSEL_I                (hsel),
        .HADDR_I               (haddr),
        .HTRANS_I              (htrans),
        .HWRITE_I              (hwrite),
        .HSIZE_I               (3'h2),
        .HWDATA_I              (hwdata),
        .HREADY_I              (hready),
        .HREADYOUT_O           (hready),
        .HRDATA_O              (hrdata),
        .HRESP_O               (hresp),
        .RTS_N_I               (rts_n),
        .RXD_I                 (rxd),
        .TXD_O                 (txd),
        .BAUD_STRAP_A_I        (sa),
        .BAUD_STRAP_B_I        (sb),
        .Y_AXIS_INVERT_STRAP_I (yinv),
        .FACTORY_TEST_STRAP_I  (ftest)
    );
    compass_host host (.clk_i(clk), .bit_cyc_i(bitc), .txd_i(txd), .rts_n_o(rts_n), .rxd_o(rxd));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // hang guard: counts as a mismatch
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_total++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // single word transfer; no wait count assumed, only the guard ends it
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic take(input int n, input int lim);
        int c;
        c = 0;
        while (host.rx_q.size() < n && c < lim) begin
            @(posedge clk);
            c++;
        end
        check(host.rx_q.size(), n, "byte count");
    endtask

    task automatic state_is(input logic [5:0] s, input string msg);
        ahb(`REG_STATUS, 1'b0, 32'h0, rd);
        check({26'h0, rd[5:0]}, {26'h0, s}, msg);
    endtask

    function automatic logic [31:0] got3(input int b);
        return {8'h0, host.rx_q[b], host.rx_q[b+1], host.rx_q[b+2]};
    endfunction

    function automatic logic [31:0] exp_pkt(input logic f, input logic [15:0] hd, input logic inv_n);
        logic [15:0] v;
        v = (inv_n == 1'b0 && hd != 16'h0) ? 16'h02d0 - hd : hd;
        return {8'h0, 7'h40, f, v};
    endfunction

    function automatic logic [31:0] div_of(input logic a, input logic b);
        case ({a, b})
            2'b11:   return 32'h80;
            2'b10:   return 32'h40;
            2'b01:   return 32'h20;
            default: return 32'h10;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h032b;
        {rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {sa, sb, yinv, ftest} = 4'hf;
        bitc = 32'h80;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        ahb(`REG_CTRL, 1'b0, 32'h0, rd);
        check(rd, 32'h0, "ctrl reset");
        ahb(`REG_HEADING, 1'b0, 32'h0, rd);
        check(rd, 32'h0, "heading reset");
        ahb(`REG_STATUS, 1'b0, 32'h0, rd);
        check({28'h0, rd[15:12]}, 32'hf, "straps open");
        state_is(compass_pkg::ST_SLEEP, "sleep after reset");
        ahb(8'h10, 1'b0, 32'h0, rd);
        check(rd, 32'h0, "unmapped read");
        check({31'h0, hresp}, 32'h0, "okay response");
        ahb(`REG_HEADING, 1'b1, 32'h3e8, rd);
        ahb(`REG_HEADING, 1'b0, 32'h0, rd);
        check(rd, 32'h2cf, "heading clamp");
        $display("register test done");
        // every baud strap combination, random heading and flag, corners at both ends
        for (int k = 0; k < 4; k++) begin
            h = (k == 0) ? 16'h0 : (k == 3) ? 16'h02cf : 16'($unsigned($random(seed)) % 720);
            flag = 1'($random(seed));
            @(posedge clk);
            sa    <= ~k[1];
            sb    <= ~k[0];
            yinv  <= (k == 3) ? 1'b1 : (k == 0) ? 1'b0 : 1'($random(seed));
            ftest <= k[0];
            repeat (6) @(posedge clk);
            bitc = div_of(sa, sb);
            ahb(`REG_CTRL, 1'b1, {31'h0, flag}, rd);
            ahb(`REG_HEADING, 1'b1, {16'h0, h}, rd);
            base = host.rx_q.size();
            host.request(1'b1, 1'b0);
            take(base + 3, 40 * bitc + 100);
            // the last byte is taken mid stop bit; the packet ends half a bit later
            repeat (bitc) @(posedge clk);
            check(got3(base), exp_pkt(flag, h, yinv), "status packet");
            ahb(`REG_PKT_CNT, 1'b0, 32'h0, rd);
            check(rd & 32'hffff, k + 1, "packet count");
            if (k == 0) begin
                repeat (CONT + 200) @(posedge clk);
                check(host.rx_q.size(), base + 3, "single packet only");
            end
            state_is(compass_pkg::ST_SLEEP, "sleep after packet");
            $display("polled test at divider %0d done", bitc);
        end
        // continuous mode at the fastest rate
        base = host.rx_q.size();
        host.request(1'b1, 1'b1);
        take(base + 3, 40 * bitc + 100);
        t0 = cyc;
        take(base + 6, CONT + 40 * bitc + 100);
        check(got3(base + 3), exp_pkt(flag, h, yinv), "repeated packet");
        check(32'(cyc - t0 >= CONT && cyc - t0 <= CONT + 30 * bitc + 40), 32'h1, "repeat spacing");
        host.release_rts();
        repeat (30 * bitc + 100) @(posedge clk);
        base = host.rx_q.size();
        repeat (CONT + 100) @(posedge clk);
        check(host.rx_q.size(), base, "continuous stops");
        check(32'(base % 3), 32'h0, "whole packets");
        state_is(compass_pkg::ST_SLEEP, "sleep after continuous");
        $display("continuous test done");
        // calibration: start reply, wait while receive low, done reply
        host.request(1'b0, 1'b0);
        take(base + 3, 40 * bitc + 100);
        check(got3(base), 32'h535441, "start reply");
        repeat (500) @(posedge clk);
        check(host.rx_q.size(), base + 3, "quiet during rotation");
        state_is(compass_pkg::ST_CAL_WAIT, "calibration wait");
        host.end_cal();
        take(base + 6, 40 * bitc + 100);
        check(got3(base + 3), 32'h524459, "done reply");
        repeat (20) @(posedge clk);
        state_is(compass_pkg::ST_SLEEP, "sleep after calibration");
        check(host.frame_err, 32'h0, "stop bits");
        $display("calibration test done");
        close_out();
    end
endmodule
`default_nettype wire
